//--- io_line_pkg.sv
// shared constants and carrier types for the io line controller
package io_line_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned LINES = 32;
    localparam int unsigned ADDR_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OWN_ENABLE_OFS = 8'h00;
    localparam logic [7:0] OWN_DISABLE_OFS = 8'h04;
    localparam logic [7:0] OWN_STATUS_OFS = 8'h08;
    localparam logic [7:0] SEL_LOW_OFS = 8'h10;
    localparam logic [7:0] SEL_HIGH_OFS = 8'h14;
    localparam logic [7:0] PULLUP_ENABLE_OFS = 8'h20;
    localparam logic [7:0] PULLUP_DISABLE_OFS = 8'h24;
    localparam logic [7:0] PULLUP_STATUS_OFS = 8'h28;
    localparam logic [7:0] PULLDOWN_ENABLE_OFS = 8'h30;
    localparam logic [7:0] PULLDOWN_DISABLE_OFS = 8'h34;
    localparam logic [7:0] PULLDOWN_STATUS_OFS = 8'h38;
    localparam logic [7:0] PIN_LEVEL_OFS = 8'h3C;

    // ------------------------------------------------------------
    // reset values (status one = resistor off, own one = controller)
    // ------------------------------------------------------------
    localparam logic [31:0] PULLUP_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] PULLDOWN_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] OWN_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] SELECT_RESET = 32'h00000000;
    localparam logic [31:0] MUX_PRESENT = 32'hFFFFFFFF;
    localparam logic [31:0] PERIPH_PRESENT = 32'hFFFFFFFF;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] out;
        logic [31:0] oe;
    } line_drive_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage

//--- line_sync.sv
// two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/1ns
module line_sync
    import io_line_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // pins in, synchronised out
    input wire logic [31:0] i_async,
    output logic [31:0] o_sync
);

    typedef struct packed {
        logic [31:0] meta;
        logic [31:0] stable;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    // first stage feeds only the second stage
    always_comb
    begin
        next_state.meta = i_async;
        next_state.stable = state.meta;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            state <= '0;
        else
            state <= next_state;
    end

    assign o_sync = state.stable;

endmodule

//--- bit_set_clear.sv
// per-line status register written through set and clear masks
`timescale 1ns/1ns
module bit_set_clear
    import io_line_pkg::*;
#(
    parameter logic [31:0] RESET_VALUE = 32'h00000000
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // one-cycle masks, zero bits leave the line alone
    input wire logic [31:0] i_set,
    input wire logic [31:0] i_clr,
    output logic [31:0] o_q
);

    logic [31:0] state;
    logic [31:0] next_state;

    // masks never act on the same cycle since strobes are exclusive
    always_comb
    begin
        next_state = (state & ~i_clr) | i_set;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            state <= RESET_VALUE;
        else
            state <= next_state;
    end

    assign o_q = state;

endmodule

//--- io_line_controller.sv
// io line controller: pull resistors, ownership and peripheral select
//
// What this block does
// - thirty-two lines, each gpio or peripheral
// - line n is bit n everywhere
// - pull-up enable and disable writes update status
// - pull-up status zero means resistor on
// - pull-down enable, disable, status, zero means on
// - pull-down enable dropped while pull-up on
// - pull-up enable dropped while pull-down on
// - pull-up control independent of line ownership
// - pull reset values chosen per line
// - ownership set and clear, one means controller
// - unmuxed lines ignore ownership writes, read one
// - ownership resets per line, normally controller
// - two select bits pick peripheral a to d
// - pin input always reaches every peripheral
// - select writes accepted whatever the ownership
// - select registers reset to peripheral a
// - missing peripheral stored, pin left undriven
// - register writes work with clock gated
// - pin level sampling and change detect need clock
// - interrupt only while peripheral clock enabled
// - peripheral-owned pin driven by selected peripheral
`timescale 1ns/1ns
module io_line_controller
    import io_line_pkg::*;
#(
    // status reset values, a one leaves that resistor off
    parameter logic [31:0] PULLUP_INIT = PULLUP_RESET,
    parameter logic [31:0] PULLDOWN_INIT = PULLDOWN_RESET,
    // ownership reset value, a one leaves the line with the controller
    parameter logic [31:0] OWN_INIT = OWN_RESET,
    // lines that have any peripheral multiplexed behind them
    parameter logic [31:0] MUX_LINES = MUX_PRESENT,
    // lines on which each single peripheral exists
    parameter logic [31:0] PERIPH_A_LINES = PERIPH_PRESENT,
    parameter logic [31:0] PERIPH_B_LINES = PERIPH_PRESENT,
    parameter logic [31:0] PERIPH_C_LINES = PERIPH_PRESENT,
    parameter logic [31:0] PERIPH_D_LINES = PERIPH_PRESENT
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // peripheral clock gate from the clock controller
    input wire logic i_periph_clk_en,
    // register port
    input wire reg_req_type i_bus,
    output logic [31:0] o_rdata,
    // controller's own output logic
    input wire line_drive_type i_ctrl,
    // peripheral outputs, index 0 is a through 3 is d
    input wire line_drive_type [3:0] i_periph,
    // pins
    input wire logic [31:0] i_pin,
    output line_drive_type o_pin,
    output logic [31:0] o_pullup_en,
    output logic [31:0] o_pulldown_en,
    // pin level towards every peripheral
    output logic [31:0] o_periph_in,
    // line change event
    output logic o_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // software-written peripheral select bits
        logic [31:0] sel_low;
        logic [31:0] sel_high;
        // pin samples, the level copy freezes while the clock is off
        logic [31:0] pin_level;
        logic [31:0] periph_in;
        // registered outputs
        logic [31:0] rdata;
        line_drive_type drive;
        logic [31:0] pullup_en;
        logic [31:0] pulldown_en;
        logic irq;
    } ctrl_state_type;

    // unmuxed lines start under the controller and can never leave it
    localparam logic [31:0] OWN_START = OWN_INIT | ~MUX_LINES;

    // registered state of this module, apart from the status registers and the pin synchroniser, lives in one struct
    ctrl_state_type state;
    ctrl_state_type next_state;

    // synchronised pins and the three status registers
    logic [31:0] pin_sync;
    logic [31:0] pullup_status;
    logic [31:0] pulldown_status;
    logic [31:0] own_status;

    // exact-match write strobes, at most one high in a cycle
    logic wr_own_enable;
    logic wr_own_disable;
    logic wr_sel_low;
    logic wr_sel_high;
    logic wr_pullup_enable;
    logic wr_pullup_disable;
    logic wr_pulldown_enable;
    logic wr_pulldown_disable;

    // one-cycle set and clear masks towards the status registers
    logic [31:0] pullup_set;
    logic [31:0] pullup_clr;
    logic [31:0] pulldown_set;
    logic [31:0] pulldown_clr;
    logic [31:0] own_set;
    logic [31:0] own_clr;

    // peripherals present per line once the mux mask is applied
    logic [31:0] periph_lines [4];

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    // pins are asynchronous, so nothing reads them before two flops
    line_sync u_pin_sync
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_async(i_pin),
        .o_sync(pin_sync)
    );

    // ------------------------------------------------------------
    // write decode into set and clear masks
    // ------------------------------------------------------------
    // exact match only, so no register answers at an alias address
    assign wr_own_enable = i_bus.wr && (i_bus.addr == OWN_ENABLE_OFS);
    assign wr_own_disable = i_bus.wr && (i_bus.addr == OWN_DISABLE_OFS);
    assign wr_sel_low = i_bus.wr && (i_bus.addr == SEL_LOW_OFS);
    assign wr_sel_high = i_bus.wr && (i_bus.addr == SEL_HIGH_OFS);
    assign wr_pullup_enable = i_bus.wr && (i_bus.addr == PULLUP_ENABLE_OFS);
    assign wr_pullup_disable = i_bus.wr && (i_bus.addr == PULLUP_DISABLE_OFS);
    assign wr_pulldown_enable = i_bus.wr && (i_bus.addr == PULLDOWN_ENABLE_OFS);
    assign wr_pulldown_disable = i_bus.wr && (i_bus.addr == PULLDOWN_DISABLE_OFS);

    // writes are plain register updates, so they need no clock enable
    // status one is resistor off, so disable sets and enable clears
    assign pullup_set = wr_pullup_disable
        ? i_bus.wdata : '0;
    assign pulldown_set = wr_pulldown_disable
        ? i_bus.wdata : '0;

    // an enable is dropped per line while the opposite resistor is on;
    // the opposite status already holds any write of the cycle before,
    // so back-to-back enables of both resistors still exclude
    assign pullup_clr = wr_pullup_enable
        ? (i_bus.wdata & pulldown_status) : '0;
    assign pulldown_clr = wr_pulldown_enable
        ? (i_bus.wdata & pullup_status) : '0;

    // lines with no peripheral behind them never leave controller hands
    assign own_set = wr_own_enable
        ? (i_bus.wdata & MUX_LINES) : '0;
    assign own_clr = wr_own_disable
        ? (i_bus.wdata & MUX_LINES) : '0;

    // ------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------
    // set wins in each cell, though exclusive strobes never collide
    // pull-up status: enable clears, disable sets
    bit_set_clear #(
        .RESET_VALUE(PULLUP_INIT)
    ) u_pullup (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_set(pullup_set),
        .i_clr(pullup_clr),
        .o_q(pullup_status)
    );

    // pull-down status: enable clears, disable sets
    bit_set_clear #(
        .RESET_VALUE(PULLDOWN_INIT)
    ) u_pulldown (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_set(pulldown_set),
        .i_clr(pulldown_clr),
        .o_q(pulldown_status)
    );

    // ownership status: enable sets (controller), disable clears
    bit_set_clear #(
        .RESET_VALUE(OWN_START)
    ) u_own (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_set(own_set),
        .i_clr(own_clr),
        .o_q(own_status)
    );

    // ------------------------------------------------------------
    // which peripherals exist on which line
    // ------------------------------------------------------------
    // an absent peripheral leaves its pin undriven when selected
    assign periph_lines[0] = PERIPH_A_LINES & MUX_LINES;
    assign periph_lines[1] = PERIPH_B_LINES & MUX_LINES;
    assign periph_lines[2] = PERIPH_C_LINES & MUX_LINES;
    assign periph_lines[3] = PERIPH_D_LINES & MUX_LINES;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [1:0] sel;
        sel = 2'h0;
        next_state = state;

        // select registers take writes whatever the ownership;
        // no check against the peripherals that really exist
        if (wr_sel_low)
        begin
            next_state.sel_low = i_bus.wdata;
        end
        if (wr_sel_high)
        begin
            next_state.sel_high = i_bus.wdata;
        end

        // pin level only moves while the peripheral clock runs;
        // with the clock off it holds what it last saw
        if (i_periph_clk_en)
        begin
            next_state.pin_level = pin_sync;
        end

        // change event needs two samples, so it needs the clock too
        next_state.irq = i_periph_clk_en
            && (pin_sync != state.pin_level);

        // peripherals see the pin whatever the selection
        next_state.periph_in = pin_sync;

        // resistor controls towards the pad, status zero means on
        next_state.pullup_en = ~pullup_status;
        next_state.pulldown_en = ~pulldown_status;

        // output steering per line; selection touches output only
        for (int i = 0; i < LINES; i++)
        begin
            sel = {state.sel_high[i], state.sel_low[i]};
            // controller ownership wins over any select value
            if (own_status[i])
            begin
                next_state.drive.out[i] = i_ctrl.out[i];
                next_state.drive.oe[i] = i_ctrl.oe[i];
            end
            // selected peripheral is present on this line
            else if (periph_lines[sel][i])
            begin
                next_state.drive.out[i] = i_periph[sel].out[i];
                next_state.drive.oe[i] = i_periph[sel].oe[i];
            end
            else
            begin
                // no such peripheral: nothing drives the pin
                next_state.drive.out[i] = 1'b0;
                next_state.drive.oe[i] = 1'b0;
            end
        end

        // read data stand only in the cycle after the read strobe
        // reads have no side effects on any status bit
        next_state.rdata = '0;
        if (i_bus.rd)
        begin
            unique case (i_bus.addr)
                OWN_STATUS_OFS:
                begin
                    next_state.rdata = own_status;
                end
                SEL_LOW_OFS:
                begin
                    next_state.rdata = state.sel_low;
                end
                SEL_HIGH_OFS:
                begin
                    next_state.rdata = state.sel_high;
                end
                PULLUP_STATUS_OFS:
                begin
                    next_state.rdata = pullup_status;
                end
                PULLDOWN_STATUS_OFS:
                begin
                    next_state.rdata = pulldown_status;
                end
                PIN_LEVEL_OFS:
                begin
                    next_state.rdata = state.pin_level;
                end
                // write-only and unmapped addresses read as zero
                default:
                begin
                    next_state.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // selects reset to a, harmless since ownership resets to controller
    // resistor outputs reset to match their status, so the pads see
    // the right resistor from the very first cycle; constants only
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= '0;
            state.sel_low <= SELECT_RESET;
            state.sel_high <= SELECT_RESET;
            state.pullup_en <= ~PULLUP_INIT;
            state.pulldown_en <= ~PULLDOWN_INIT;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    // pin drive lags the controls by one cycle, traded for clean outputs
    // no output is a decode, so none can glitch towards the pads
    assign o_rdata = state.rdata;
    assign o_pin = state.drive;
    assign o_pullup_en = state.pullup_en;
    assign o_pulldown_en = state.pulldown_en;
    assign o_periph_in = state.periph_in;
    assign o_irq = state.irq;

endmodule

//--- io_line_assertions.sv
// checker for the io line controller ports
`timescale 1ns/1ns
module io_line_checker
    import io_line_pkg::*;
#(
    parameter logic [31:0] MUX_LINES = 32'hFFFFFFFF
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // watched inputs
    input wire logic i_periph_clk_en,
    input wire reg_req_type i_bus,
    input wire logic [31:0] i_pin,
    // watched outputs
    input wire logic [31:0] o_rdata,
    input wire logic [31:0] o_pullup_en,
    input wire logic [31:0] o_pulldown_en,
    input wire logic [31:0] o_periph_in,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic [1:0] age;

    // ------------------------------------------------------------
    // history guard: pin pipeline is only valid three edges in
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data not idle");
    a_pull_excl: assert property ((o_pullup_en & o_pulldown_en) == 32'h0)
        else $error("both resistors on");
    a_pullup_set: assert property (i_bus.wr && i_bus.addr == PULLUP_ENABLE_OFS
        && !$past(i_bus.wr) |-> ##2 (o_pullup_en & $past(i_bus.wdata, 2)
        & ~$past(o_pulldown_en, 2)) == ($past(i_bus.wdata, 2) & ~$past(o_pulldown_en, 2)))
        else $error("pull-up enable lost");
    a_pulldown_set: assert property (i_bus.wr && i_bus.addr == PULLDOWN_ENABLE_OFS
        && !$past(i_bus.wr) |-> ##2 (o_pulldown_en & $past(i_bus.wdata, 2)
        & ~$past(o_pullup_en, 2)) == ($past(i_bus.wdata, 2) & ~$past(o_pullup_en, 2)))
        else $error("pull-down enable lost");
    a_pullup_clear: assert property (i_bus.wr && i_bus.addr == PULLUP_DISABLE_OFS
        |-> ##2 (o_pullup_en & $past(i_bus.wdata, 2)) == 32'h0)
        else $error("pull-up disable lost");
    a_irq_gated: assert property (o_irq |-> $past(i_periph_clk_en))
        else $error("event without clock");
    a_periph_in: assert property (age == 2'h3 |-> o_periph_in == $past(i_pin, 3))
        else $error("peripheral input path wrong");
    a_sel_back: assert property (i_bus.wr && i_bus.addr == SEL_LOW_OFS ##2
        i_bus.rd && i_bus.addr == SEL_LOW_OFS |=> o_rdata == $past(i_bus.wdata, 3))
        else $error("select readback wrong");
    a_own_unmux: assert property (i_bus.rd && i_bus.addr == OWN_STATUS_OFS
        |=> (o_rdata | MUX_LINES) == 32'hFFFFFFFF)
        else $error("unmuxed line not owned");
    a_unmapped_rd: assert property (i_bus.rd && i_bus.addr == 8'h40 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    c_irq: cover property (o_irq);
    c_pulldown: cover property (o_pulldown_en != 32'h0);
    c_own_rd: cover property (i_bus.rd && i_bus.addr == OWN_STATUS_OFS);
endmodule

bind io_line_controller io_line_checker #(.MUX_LINES(MUX_LINES)) u_chk (.i_clk, .i_resetn,
    .i_periph_clk_en, .i_bus, .i_pin, .o_rdata, .o_pullup_en, .o_pulldown_en,
    .o_periph_in, .o_irq);

//--- io_line_partner.sv
// far-side model: clock gate, pins, controller and peripheral drives
`timescale 1ns/1ns
module io_line_partner
    import io_line_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // bench requests
    input wire logic i_clk_req,
    input wire logic [31:0] i_level,
    // towards the controller
    output logic o_clk_en,
    output line_drive_type o_ctrl,
    output line_drive_type [3:0] o_periph,
    output logic [31:0] o_pin
);
    // gate stays shut after reset until software asks for it
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_clk_en <= 1'b0;
        else
            o_clk_en <= i_clk_req;
    end

    // distinct drives per source, so a wrong route shows at once
    assign o_ctrl = {32'h12345678, 32'hFFFF0000};
    assign o_periph[0] = {32'hA5A5A5A5, 32'h0F0F0F0F};
    assign o_periph[1] = {32'h5A5A5A5A, 32'hF0F0F0F0};
    assign o_periph[2] = {32'hC3C3C3C3, 32'h33333333};
    assign o_periph[3] = {32'h3C3C3C3C, 32'hCCCCCCCC};
    assign o_pin = i_level;
endmodule

//--- io_line_controller_tb_top.sv
// self-checking bench for the io line controller
`timescale 1ns/1ns
`define CHK(name, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("mismatch %s exp %h got %h", name, exp, got); \
        end \
    end
module io_line_controller_tb_top
    import io_line_pkg::*;
;
    logic clk, resetn, clk_req, clk_en, irq;
    reg_req_type bus;
    logic [31:0] level, pin_in, rdata, pu_en, pd_en, p_in;
    line_drive_type ctrl, pin;
    line_drive_type [3:0] periph;
    int err_count = 0;
    int checks_done = 0;
    int irq_seen = 0;
    logic [7:0] ra [6] = '{OWN_STATUS_OFS, SEL_LOW_OFS, SEL_HIGH_OFS,
        PULLUP_STATUS_OFS, PULLDOWN_STATUS_OFS, 8'h40};
    logic [31:0] re [6] = '{32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0};

    io_line_controller #(.MUX_LINES(32'hFFFFFFFE), .PERIPH_D_LINES(32'h7FFFFFFF)) i_dut (
        .i_clk(clk), .i_resetn(resetn), .i_periph_clk_en(clk_en), .i_bus(bus),
        .o_rdata(rdata), .i_ctrl(ctrl), .i_periph(periph), .i_pin(pin_in), .o_pin(pin),
        .o_pullup_en(pu_en), .o_pulldown_en(pd_en), .o_periph_in(p_in), .o_irq(irq));
    io_line_partner i_far (.i_clk(clk), .i_resetn(resetn), .i_clk_req(clk_req),
        .i_level(level), .o_clk_en(clk_en), .o_ctrl(ctrl), .o_periph(periph),
        .o_pin(pin_in));

    // ------------------------------------------------------------
    // clock, event counter and bus tasks
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // falling edge keeps the count clear of the launch race
    always @(negedge clk)
        if (irq === 1'b1)
            irq_seen++;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rdk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 `CHK(n, e, rdata)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // line 0 stays with the controller, line 31 has no peripheral d
    function automatic line_drive_type route(input int k);
        logic [31:0] pres;
        pres = (k == 3) ? 32'h7FFFFFFF : 32'hFFFFFFFF;
        route.out = (ctrl.out & 32'h1) | (periph[k].out & 32'hFFFFFFFE & pres);
        route.oe = (ctrl.oe & 32'h1) | (periph[k].oe & 32'hFFFFFFFE & pres);
    endfunction
    task final_report;
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence; the clock gate stays off for all the writes
    // ------------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        clk_req = 1'b0;
        level = 32'h0;
        bus = '0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rdk("reset", ra[i], re[i]);
        idle(2);
        `CHK("pin", ctrl, pin)
        wr(OWN_DISABLE_OFS, 32'hFFFFFFFF);
        rdk("own", OWN_STATUS_OFS, 32'h1);
        wr(PULLUP_ENABLE_OFS, 32'h3);
        wr(PULLDOWN_ENABLE_OFS, 32'h6);
        wr(PULLUP_ENABLE_OFS, 32'h4);
        wr(PULLUP_STATUS_OFS, 32'h0);
        rdk("pu", PULLUP_STATUS_OFS, 32'hFFFFFFFC);
        rdk("pd", PULLDOWN_STATUS_OFS, 32'hFFFFFFFB);
        idle(2);
        `CHK("pu_en", 32'h3, pu_en)
        `CHK("pd_en", 32'h4, pd_en)
        wr(PULLUP_DISABLE_OFS, 32'h3);
        wr(PULLDOWN_DISABLE_OFS, 32'h4);
        rdk("pu", PULLUP_STATUS_OFS, 32'hFFFFFFFF);
        rdk("pd", PULLDOWN_STATUS_OFS, 32'hFFFFFFFF);
        for (int k = 0; k < 4; k++)
        begin
            wr(SEL_LOW_OFS, {32{k[0]}});
            rdk("sel", SEL_LOW_OFS, {32{k[0]}});
            wr(SEL_HIGH_OFS, {32{k[1]}});
            idle(3);
            `CHK("pin", route(k), pin)
        end
        wr(OWN_ENABLE_OFS, 32'hFFFFFFFF);
        idle(3);
        `CHK("pin", ctrl, pin)
        @(posedge clk);
        level <= 32'h10;
        idle(5);
        `CHK("p_in", 32'h10, p_in)
        rdk("lvl", PIN_LEVEL_OFS, 32'h0);
        `CHK("irq", 0, irq_seen)
        @(posedge clk);
        clk_req <= 1'b1;
        idle(5);
        rdk("lvl", PIN_LEVEL_OFS, 32'h10);
        irq_seen = 0;
        @(posedge clk);
        level <= 32'h11;
        idle(6);
        `CHK("irq", 1, irq_seen)
        @(posedge clk);
        clk_req <= 1'b0;
        idle(3);
        irq_seen = 0;
        @(posedge clk);
        level <= 32'h13;
        idle(6);
        `CHK("irq", 0, irq_seen)
        `CHK("p_in", 32'h13, p_in)
        rdk("lvl", PIN_LEVEL_OFS, 32'h11);
        final_report;
    end

    // watchdog well beyond the hundred-odd cycles the run needs
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule
